// ### adc_readout_regs.svh
// Constants for the serial result readout chain
//
// Contract
// (RULE1) Ready goes low on new result; host waits
// (RULE2) Ready timed by divided internal clock; host polls
// (RULE3) Unread result overwritten at next ready
// (RULE4) Offset binary words, 20 bits or 16
// (RULE5) Zero input gives code 0x01000
// (RULE6) Codes saturate at all ones and zeros
// (RULE7) Result loaded at ready; shift on falling edges
// (RULE8) Host keeps data clock quiet around toggle
// (RULE9) Chain input passes through to serial output
// (RULE10) Chain input sampled on data clock falling edge
// (RULE11) 64 words per device per readout
// (RULE12) Ready falls on a system clock falling edge
// (RULE13) Ready returns high after a data clock fall
// (RULE14) Readout before toggle finishes before quiet interval
// (RULE15) Readout after toggle waits quiet interval
// (RULE16) Readout spanning toggle pauses around its edge
// (RULE17) Host holds data clock low when idle
// (RULE18) Configuration bit 8 selects 20-bit words
// (RULE19) Host counts devices times 64 times width
`ifndef ADC_READOUT_REGS_SVH
`define ADC_READOUT_REGS_SVH

`define CHANNELS 64
`define WORD_W_LONG 20
`define WORD_W_SHORT 16
`define SHIFT_W 1280
`define CHAIN_TAP_SHORT 256
`define FMT_BIT 8
`define ZERO_CODE 20'h01000
`define FULL_CODE 20'hfffff
`define EMPTY_CODE 20'h00000
`define SAMPLE_W 22
`define RDY_DIV_RATIO 4
`define RDY_DIV_W 2
`define CLK_PERIOD_NS 8
`define TOGGLE_QUIET_NS 2000
`define TOGGLE_QUIET_CYC ((`TOGGLE_QUIET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUIET_CNT_W 9

`endif

// ### adc_readout_pkg.sv
// Types for the serial result readout chain
package adc_readout_pkg;
	typedef enum logic [1:0] {RD_IDLE, RD_PENDING, RD_READY, RD_SHIFTING} rd_state_t;
endpackage

// ### adc_readout_chain.sv
// Serial result readout with ready indication and daisy chain
`timescale 1ns/10ps
`include "adc_readout_regs.svh"

module adc_readout_chain (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [15:0] config_word_i,
	input wire logic result_wr_i,
	input wire logic [5:0] result_idx_i,
	input wire logic signed [`SAMPLE_W-1:0] result_sample_i,
	input wire logic result_done_i,
	input wire logic readout_clock_i,
	input wire logic chain_in_i,
	input wire logic integration_toggle_i,
	output logic result_ready_n_o,
	output logic serial_out_o,
	output logic quiet_violation_o
);

	// ----------------------------------------
	// Code conversion
	// ----------------------------------------
	function automatic logic [`WORD_W_LONG-1:0] to_code(input logic signed [`SAMPLE_W-1:0] s);
		logic signed [`SAMPLE_W:0] t;
		t = `SAMPLE_W'(s) + $signed({3'h0, `ZERO_CODE});
		if (t < 0)
			to_code = `EMPTY_CODE;
		else if (t > $signed({3'h0, `FULL_CODE}))
			to_code = `FULL_CODE;
		else
			to_code = t[`WORD_W_LONG-1:0];
	endfunction

	logic [`WORD_W_LONG-1:0] bank_q [`CHANNELS];
	logic [`SHIFT_W-1:0] shift_q;
	logic [`SHIFT_W-1:0] shift_d;
	logic [`SHIFT_W-1:0] load20;
	logic [`SHIFT_W-1:0] load16;
	logic [2:0] readout_clock_s_q;
	logic [1:0] chain_s_q;
	logic [2:0] tog_s_q;
	logic [`RDY_DIV_W-1:0] div_q;
	logic ready_set;
	logic readout_clock_fall;
	logic tog_edge;
	logic fmt20;
	logic [`QUIET_CNT_W-1:0] since_tog_q;
	logic [`QUIET_CNT_W-1:0] since_fall_q;
	adc_readout_pkg::rd_state_t state_q;

	assign fmt20 = config_word_i[`FMT_BIT]; // RULE18
	assign readout_clock_fall = readout_clock_s_q[2] & ~readout_clock_s_q[1];
	assign tog_edge = tog_s_q[2] ^ tog_s_q[1];

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			readout_clock_s_q <= 3'h0;
			chain_s_q <= 2'h0;
			tog_s_q <= 3'h0;
		end else begin
			readout_clock_s_q <= {readout_clock_s_q[1:0], readout_clock_i};
			chain_s_q <= {chain_s_q[0], chain_in_i};
			tog_s_q <= {tog_s_q[1:0], integration_toggle_i};
		end
	end

	// ----------------------------------------
	// Result bank
	// ----------------------------------------
	// Offset and saturation applied on write
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `CHANNELS; i++)
				bank_q[i] <= `EMPTY_CODE;
		end else if (result_wr_i) begin
			bank_q[result_idx_i] <= to_code(result_sample_i); // RULE5 RULE6
		end
	end

	// ----------------------------------------
	// Internal divided clock and ready state
	// ----------------------------------------
	// Divider free-runs so ready phase is not tied to the toggle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			div_q <= `RDY_DIV_W'h0;
		else
			div_q <= div_q + `RDY_DIV_W'h1; // RULE2
	end

	assign ready_set = (state_q == adc_readout_pkg::RD_PENDING) && (div_q == `RDY_DIV_W'h0);

	// Pending result waits for the next internal tick
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= adc_readout_pkg::RD_IDLE;
		end else begin
			case (state_q)
				adc_readout_pkg::RD_IDLE: begin
					if (result_done_i)
						state_q <= adc_readout_pkg::RD_PENDING;
				end
				adc_readout_pkg::RD_PENDING: begin
					if (ready_set)
						state_q <= adc_readout_pkg::RD_READY;
				end
				adc_readout_pkg::RD_READY, adc_readout_pkg::RD_SHIFTING: begin
					if (result_done_i)
						state_q <= adc_readout_pkg::RD_PENDING; // RULE3
					else if (readout_clock_fall)
						state_q <= adc_readout_pkg::RD_SHIFTING;
				end
				default: begin
					state_q <= adc_readout_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// Ready output changes on the falling system clock edge
	always_ff @(negedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			result_ready_n_o <= 1'b1;
		else if (ready_set)
			result_ready_n_o <= 1'b0; // RULE1 RULE12
		else if (readout_clock_fall && !result_ready_n_o)
			result_ready_n_o <= 1'b1; // RULE13
	end

	// ----------------------------------------
	// Shift path
	// ----------------------------------------
	// Words packed from the top, channel 0 first
	generate
		for (genvar g = 0; g < `CHANNELS; g++) begin : g_pack
			assign load20[`SHIFT_W-1-`WORD_W_LONG*g -: `WORD_W_LONG] = bank_q[g];
			assign load16[`SHIFT_W-1-`WORD_W_SHORT*g -: `WORD_W_SHORT] =
				bank_q[g][`WORD_W_LONG-1 -: `WORD_W_SHORT]; // RULE4
		end
	endgenerate
	assign load16[`CHAIN_TAP_SHORT-1:0] = '0;

	// Chain bit enters right behind the last local word
	always_comb begin
		shift_d = {shift_q[`SHIFT_W-2:0], chain_s_q[1]}; // RULE9 RULE10
		if (!fmt20)
			shift_d[`CHAIN_TAP_SHORT] = chain_s_q[1]; // RULE11
	end

	// Load wins over a coincident shift
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			shift_q <= '0;
		else if (ready_set)
			shift_q <= fmt20 ? load20 : load16; // RULE3 RULE7
		else if (readout_clock_fall)
			shift_q <= shift_d; // RULE7
	end

	assign serial_out_o = shift_q[`SHIFT_W-1];

	// ----------------------------------------
	// Quiet interval monitor
	// ----------------------------------------
	// Counters saturate at the quiet interval length
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			since_tog_q <= `QUIET_CNT_W'(`TOGGLE_QUIET_CYC);
			since_fall_q <= `QUIET_CNT_W'(`TOGGLE_QUIET_CYC);
		end else begin
			if (tog_edge)
				since_tog_q <= `QUIET_CNT_W'h0;
			else if (since_tog_q < `QUIET_CNT_W'(`TOGGLE_QUIET_CYC))
				since_tog_q <= since_tog_q + `QUIET_CNT_W'h1;
			if (readout_clock_fall)
				since_fall_q <= `QUIET_CNT_W'h0;
			else if (since_fall_q < `QUIET_CNT_W'(`TOGGLE_QUIET_CYC))
				since_fall_q <= since_fall_q + `QUIET_CNT_W'h1;
		end
	end

	// Sticky flag for clocking near a toggle edge
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			quiet_violation_o <= 1'b0;
		else if ((readout_clock_fall && since_tog_q < `QUIET_CNT_W'(`TOGGLE_QUIET_CYC)) ||
			(tog_edge && since_fall_q < `QUIET_CNT_W'(`TOGGLE_QUIET_CYC)))
			quiet_violation_o <= 1'b1; // RULE8
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// Ready flop acts mid-cycle, so its new level is sampled at the closing edge
	AST_READY_FALLS: assert property (ready_set |-> !result_ready_n_o) // RULE1 RULE12
		else $error("ready did not fall on tick");
	AST_READY_RISES: assert property (readout_clock_fall && !ready_set |-> result_ready_n_o) // RULE13
		else $error("ready did not rise after data clock fall");
	AST_TICK_SPACING: assert property (ready_set |=> !ready_set [*3]) // RULE2
		else $error("ready ticks closer than divider");
	AST_FIRST_BIT: assert property (ready_set |=> serial_out_o == $past(bank_q[0][19])) // RULE7
		else $error("first bit not channel 0 msb");
	AST_SHIFT_ADV: assert property ( // RULE7
		readout_clock_fall && !ready_set |=> serial_out_o == $past(shift_q[1278]))
		else $error("serial output did not advance");
	AST_CHAIN_LONG: assert property ( // RULE9 RULE10
		readout_clock_fall && !ready_set && fmt20 |=> shift_q[0] == $past(chain_s_q[1]))
		else $error("chain bit not taken in 20-bit mode");
	AST_CHAIN_SHORT: assert property ( // RULE9 RULE11
		readout_clock_fall && !ready_set && !fmt20 |=> shift_q[256] == $past(chain_s_q[1]))
		else $error("chain bit not taken in 16-bit mode");
	AST_TRUNC: assert property ( // RULE4 RULE18
		ready_set && !fmt20 |=> shift_q[1279:1264] == $past(bank_q[0][19:4]))
		else $error("16-bit word not truncated");
	AST_ZERO_CODE: assert property ( // RULE5
		result_wr_i && result_sample_i == 0 |=> bank_q[$past(result_idx_i)] == 20'h01000)
		else $error("zero input not offset");
	AST_SAT_HIGH: assert property ( // RULE6
		result_wr_i && result_sample_i > 22'sh0fefff |=> bank_q[$past(result_idx_i)] == 20'hfffff)
		else $error("high saturation missing");
	AST_SAT_LOW: assert property ( // RULE6
		result_wr_i && result_sample_i < -22'sh1000 |=> bank_q[$past(result_idx_i)] == 20'h00000)
		else $error("low saturation missing");

	COV_READY: cover property (ready_set ##[1:20] readout_clock_fall);
	COV_SHORT_MODE: cover property (ready_set && !fmt20);
	COV_OVERWRITE: cover property (!result_ready_n_o ##1 result_done_i);
	COV_QUIET_FLAG: cover property (!quiet_violation_o ##1 quiet_violation_o);

endmodule

// ### host_model.sv
// Host model driving data clock, toggle and chain input
`timescale 1ns/10ps
module host_model (
	input wire logic clk_sys_i,
	input wire logic serial_out_i,
	output logic readout_clock_o,
	output logic integration_toggle_o,
	output logic chain_in_o
);
	// Data clock idles low
	initial begin
		readout_clock_o = 1'b0;
		integration_toggle_o = 1'b0;
		chain_in_o = 1'b0;
	end
	// Toggle edge with quiet time on both sides
	task automatic toggle(input int q);
		repeat (q) @(negedge clk_sys_i);
		integration_toggle_o = ~integration_toggle_o;
		repeat (q) @(negedge clk_sys_i);
	endtask
	// One data clock period, bit taken before the fall
	task automatic shift(input logic din, output logic b);
		b = serial_out_i;
		chain_in_o = din;
		repeat (4) @(negedge clk_sys_i);
		readout_clock_o = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		readout_clock_o = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		chain_in_o = ~din; // Hold over, stale value gone
		repeat (3) @(negedge clk_sys_i);
	endtask
	// Word collected MSB first
	task automatic read_word(input int w, output logic [19:0] v);
		logic b;
		v = 20'h00000;
		for (int i = 0; i < w; i++) begin
			shift(1'b0, b);
			v = {v[18:0], b};
		end
	endtask
endmodule

// ### adc_readout_chain_tb_top.sv
// Testbench for the serial result readout chain
`timescale 1ns/10ps
`include "adc_readout_regs.svh"
module adc_readout_chain_tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] config_word_i = 16'h0100;
	logic result_wr_i = 1'b0;
	logic [5:0] result_idx_i = 6'h00;
	logic signed [`SAMPLE_W-1:0] result_sample_i = '0;
	logic result_done_i = 1'b0;
	logic readout_clock_i;
	logic chain_in_i;
	logic integration_toggle_i;
	logic result_ready_n_o;
	logic serial_out_o;
	logic quiet_violation_o;
	int num_errors = 0;
	int total_checks = 0;
	logic [19:0] v;
	logic b;
	// 125 MHz clock
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	adc_readout_chain adc_readout_chain_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.config_word_i(config_word_i), .result_wr_i(result_wr_i),
		.result_idx_i(result_idx_i), .result_sample_i(result_sample_i),
		.result_done_i(result_done_i), .readout_clock_i(readout_clock_i),
		.chain_in_i(chain_in_i), .integration_toggle_i(integration_toggle_i),
		.result_ready_n_o(result_ready_n_o), .serial_out_o(serial_out_o),
		.quiet_violation_o(quiet_violation_o));
	host_model host_model_i (.clk_sys_i(clk_sys_i), .serial_out_i(serial_out_o),
		.readout_clock_o(readout_clock_i), .integration_toggle_o(integration_toggle_i),
		.chain_in_o(chain_in_i));
	// ----------------
	// Helpers
	// ----------------
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic signed [`SAMPLE_W-1:0] s);
		@(negedge clk_sys_i);
		result_wr_i = 1'b1;
		result_idx_i = idx;
		result_sample_i = s;
		@(negedge clk_sys_i);
		result_wr_i = 1'b0;
	endtask
	task automatic integration_toggle();
		int n;
		n = 0;
		@(negedge clk_sys_i) result_done_i = 1'b1;
		@(negedge clk_sys_i) result_done_i = 1'b0;
		// Ready moves on the falling edge, so poll it on the rising one
		while (result_ready_n_o !== 1'b0 && n < 20) begin
			@(posedge clk_sys_i);
			n++;
		end
		@(negedge clk_sys_i);
		check(result_ready_n_o, 1'b0);
		check(n < 6, 1'b1);
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_formats();
		config_word_i = 16'h0100;
		wr(0, 0);
		wr(1, 22'sh0fffff);
		wr(2, -22'sh001001);
		wr(3, 22'sh000010);
		integration_toggle();
		host_model_i.read_word(20, v);
		check(v, 20'h01000);
		check(result_ready_n_o, 1'b1);
		host_model_i.read_word(20, v);
		check(v, 20'hfffff);
		host_model_i.read_word(20, v);
		check(v, 20'h00000);
		host_model_i.read_word(20, v);
		check(v, 20'h01010);
	endtask
	task automatic t_short();
		config_word_i = 16'h0000;
		integration_toggle();
		host_model_i.read_word(16, v);
		check(v, 20'h00100);
		host_model_i.read_word(16, v);
		check(v, 20'h0ffff);
	endtask
	task automatic t_overwrite();
		config_word_i = 16'h0100;
		wr(0, 22'sh000005);
		integration_toggle();
		wr(0, 22'sh000007);
		integration_toggle();
		host_model_i.read_word(20, v);
		check(v, 20'h01007);
	endtask
	// Both word widths: local bits first, then the alternating chain pattern
	task automatic t_chain();
		for (int m = 0; m < 2; m++) begin
			config_word_i = m[0] ? 16'h0100 : 16'h0000;
			integration_toggle();
			for (int i = 0; i < `CHANNELS * (m[0] ? `WORD_W_LONG : `WORD_W_SHORT); i++) begin
				host_model_i.shift(i[0], b);
			end
			host_model_i.read_word(4, v);
			check(v, 20'h00005);
		end
	endtask
	task automatic t_quiet();
		host_model_i.toggle(260);
		host_model_i.shift(1'b0, b);
		check(quiet_violation_o, 1'b0);
		host_model_i.toggle(0);
		host_model_i.shift(1'b0, b);
		check(quiet_violation_o, 1'b1);
	endtask
	// Watchdog
	initial begin
		#600000;
		num_errors++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		repeat (12) @(negedge clk_sys_i);
		rst_i = 1'b0;
		@(negedge clk_sys_i);
		check(result_ready_n_o, 1'b1);
		check(serial_out_o, 1'b0);
		t_formats();
		t_short();
		t_overwrite();
		t_chain();
		t_quiet();
		report_and_stop();
	end
endmodule
